// ===== rtl/universal_shift_unit.sv
// Function
// - 8-bit shift register read and written directly by the CPU, unbuffered.
// - MSB drives a wire-mode-chosen output pin through a transparent latch.
// - serial input always taken from the serial data input pin.
// - 4-bit counter, CPU readable and writable, raises overflow interrupt.
// - shift register and counter advance on the same selected clock, except that COUNT_ON_TOGGLE moves the counter to toggle strobes.
// - external clock: counter counts both edges, or toggle strobes if COUNT_ON_TOGGLE is set.
// - clock from pin, timer 0 compare match or software strobe.
// - two-wire mode: start condition raises an interrupt.
// - two-wire mode: hold clock low after start and after overflow.
// - three-wire mode is data modes 0 and 1, no slave select.
// - master and slave exchange contents after eight serial clocks.
// - edge select zero: sample on rising, change output on falling.
// - edge select one: sample on falling, change output on rising.
// - toggle strobe toggles the serial clock pin.
// - data loaded and driver enabled half a clock before sampling; counter from zero.
// - sixteen counted edges overflow the counter, flagging byte done.
// - overflow interrupt can wake processor from idle.
// - two-wire clock at most sys/16, three-wire at most sys/4.
// - two-wire physical layer without slew limiting or noise filtering.
// - master makes the two-wire clock; slave uses clock control.
// - two-wire mode shifts on the rising edge.
// - overflow flag sets on 15 to 0; clearing releases overflow hold.
// - writing one to start flag clears it and releases start hold.
// - latch open first half-cycle on external clock, always on internal.
// - CPU write coinciding with a shift keeps the written value.
`timescale 1ns/1ps
`default_nettype none

module universal_shift_unit #(
	parameter int LINK_PERIOD_NS = shift_unit_pkg::LINK_PERIOD_NS
) (
	input wire logic CLK_SYS, // system clock
	input wire logic RESET, // synchronous reset, active high
	input wire logic LINK_CLK, // serial clock pin as clock
	input wire logic SERIAL_CLOCK_PIN_IN, // serial clock pin level
	input wire logic SERIAL_DATA_INPUT, // serial data input pin level
	input wire logic [1:0] WIRE_MODE_SELECT, // wire mode
	input wire logic CLOCK_SOURCE_SELECT, // 1 = external pin clock
	input wire logic EXTERNAL_EDGE_SELECT, // sampling edge / internal source
	input wire logic COUNT_ON_TOGGLE, // external clock: count toggle strobes
	input wire logic SOFTWARE_CLOCK_STROBE, // one-cycle software clock
	input wire logic CLOCK_PIN_TOGGLE_STROBE, // one-cycle pin toggle
	input wire logic TIMER0_MATCH, // one-cycle compare match
	input wire logic CLOCK_PIN_DRIVE, // clock pin direction, 1 = output
	input wire logic DATA_PIN_DRIVE, // data pin direction, 1 = output
	input wire logic DATA_WRITE, // shift register write strobe
	input wire logic [7:0] DATA_WRITE_VALUE, // shift register write data
	input wire logic COUNT_WRITE, // counter write strobe
	input wire logic [3:0] COUNT_WRITE_VALUE, // counter write data
	input wire logic OVERFLOW_FLAG_CLEAR, // write one to overflow flag
	input wire logic START_FLAG_CLEAR, // write one to start flag
	input wire logic OVERFLOW_IRQ_ENABLE, // overflow interrupt enable
	input wire logic START_IRQ_ENABLE, // start interrupt enable
	output logic [7:0] SHIFT_DATA, // shift register contents
	output logic [3:0] COUNT_VALUE, // counter contents
	output logic COUNTER_OVERFLOW_FLAG, // sticky overflow flag
	output logic START_CONDITION_FLAG, // sticky start flag
	output logic OVERFLOW_IRQ, // overflow interrupt, also idle wake
	output logic START_IRQ, // start interrupt
	output logic DATA_OUT, // three-wire data output
	output logic DATA_OUT_OE_N, // three-wire data output enable
	output logic SDA_OUT, // two-wire data output level
	output logic SDA_OE_N, // two-wire data open-drain enable
	output logic SERIAL_CLOCK_PIN_OUT, // clock pin output level
	output logic SERIAL_CLOCK_PIN_OE_N // clock pin output enable
);

	initial begin
		assert (LINK_PERIOD_NS >= shift_unit_pkg::THREE_WIRE_MIN_PERIOD_NS)
			else $error("link clock faster than the unit can follow");
		assert (shift_unit_pkg::DATA_WIDTH == 8)
			else $error("shift register must be eight bits wide");
		assert (shift_unit_pkg::COUNT_WIDTH == 4)
			else $error("counter must be four bits wide");
		assert (shift_unit_pkg::MSB_POS == shift_unit_pkg::DATA_WIDTH - 1)
			else $error("output bit must be the top bit");
		assert (shift_unit_pkg::COUNT_MAX == {shift_unit_pkg::COUNT_WIDTH{1'b1}})
			else $error("counter must wrap at all ones");
		assert (shift_unit_pkg::TWO_WIRE_DIVIDE >= shift_unit_pkg::THREE_WIRE_DIVIDE)
			else $error("two-wire clock limit must not exceed three-wire limit");
	end

	function automatic logic is_two_wire(input logic [1:0] m);
		is_two_wire = (m == 2'(shift_unit_pkg::WIRE_TWO)) || (m == 2'(shift_unit_pkg::WIRE_TWO_HOLD));
	endfunction

	// a set in the same cycle as a clear wins
	function automatic logic sticky_next(input logic set, input logic q, input logic clear);
		sticky_next = set | (q & ~clear);
	endfunction

	// ---- link domain: capture data on each pin edge and flag it by toggle
	logic link_rst_s1_q, link_rst_q;
	logic rise_tog_q, rise_data_q, fall_tog_q, fall_data_q;
	logic rise_tog_d, rise_data_d, fall_tog_d, fall_data_d;

	always_ff @(posedge LINK_CLK) begin
		link_rst_s1_q <= RESET;
		link_rst_q <= link_rst_s1_q;
	end

	always_comb begin
		rise_tog_d = link_rst_q ? 1'b0 : ~rise_tog_q;
		rise_data_d = link_rst_q ? 1'b0 : SERIAL_DATA_INPUT;
		fall_tog_d = link_rst_q ? 1'b0 : ~fall_tog_q;
		fall_data_d = link_rst_q ? 1'b0 : SERIAL_DATA_INPUT;
	end

	always_ff @(posedge LINK_CLK) begin
		rise_tog_q <= rise_tog_d;
		rise_data_q <= rise_data_d;
	end

	always_ff @(negedge LINK_CLK) begin
		fall_tog_q <= fall_tog_d;
		fall_data_q <= fall_data_d;
	end

	// ---- system domain synchronisers
	logic [2:0] rise_s_q, fall_s_q, scl_s_q, sda_s_q;
	logic [2:0] rise_s_d, fall_s_d, scl_s_d, sda_s_d;
	shift_unit_pkg::edge_event_t ext_edge;

	always_comb begin
		rise_s_d = {rise_s_q[1:0], rise_tog_q};
		fall_s_d = {fall_s_q[1:0], fall_tog_q};
		scl_s_d = {scl_s_q[1:0], SERIAL_CLOCK_PIN_IN};
		sda_s_d = {sda_s_q[1:0], SERIAL_DATA_INPUT};
		ext_edge.rise = rise_s_q[1] ^ rise_s_q[2];
		ext_edge.fall = fall_s_q[1] ^ fall_s_q[2];
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			rise_s_q <= 3'h0;
			fall_s_q <= 3'h0;
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
		end else begin
			rise_s_q <= rise_s_d;
			fall_s_q <= fall_s_d;
			scl_s_q <= scl_s_d;
			sda_s_q <= sda_s_d;
		end
	end

	// ---- clock source selection
	logic two_wire;
	logic sample_rise;
	shift_unit_pkg::step_t step;

	always_comb begin
		two_wire = is_two_wire(WIRE_MODE_SELECT);
		sample_rise = two_wire || !EXTERNAL_EDGE_SELECT;
		step = '0;
		if (CLOCK_SOURCE_SELECT) begin
			step.shift = sample_rise ? ext_edge.rise : ext_edge.fall;
			step.data_bit = sample_rise ? rise_data_q : fall_data_q;
			step.count = COUNT_ON_TOGGLE ? CLOCK_PIN_TOGGLE_STROBE : (ext_edge.rise | ext_edge.fall);
		end else begin
			step.shift = EXTERNAL_EDGE_SELECT ? TIMER0_MATCH : SOFTWARE_CLOCK_STROBE;
			step.count = step.shift;
			step.data_bit = sda_s_q[1];
		end
	end

	// ---- shift register
	logic [7:0] data_q, data_d;

	always_comb begin
		data_d = data_q;
		// a write wins over a coincident shift
		if (DATA_WRITE) begin
			data_d = DATA_WRITE_VALUE;
		end else if (step.shift) begin
			data_d = {data_q[6:0], step.data_bit};
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			data_q <= shift_unit_pkg::DATA_RESET;
		end else begin
			data_q <= data_d;
		end
	end

	// ---- edge and bit counter
	logic [3:0] count_q, count_d;
	logic ovf_event;

	always_comb begin
		count_d = count_q;
		// counts strobes or pin edges, whichever the source selects
		if (COUNT_WRITE) begin
			count_d = COUNT_WRITE_VALUE;
		end else if (step.count) begin
			count_d = 4'(count_q + 4'h1);
		end
		// a written count never overflows in the same cycle
		ovf_event = !COUNT_WRITE && step.count && (count_q == shift_unit_pkg::COUNT_MAX);
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			count_q <= shift_unit_pkg::COUNT_RESET;
		end else begin
			count_q <= count_d;
		end
	end

	// ---- overflow flag
	logic ovf_q, ovf_d;

	always_comb begin
		ovf_d = sticky_next(ovf_event, ovf_q, OVERFLOW_FLAG_CLEAR);
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= ovf_d;
		end
	end

	// ---- start detector and its clock hold
	logic start_q, start_d, start_hold_q, start_hold_d;
	logic start_event;

	always_comb begin
		// data falls while the clock stands high
		start_event = two_wire && scl_s_q[1] && sda_s_q[2] && !sda_s_q[1];
		start_d = sticky_next(start_event, start_q, START_FLAG_CLEAR);
		// hold begins once the master pulls the clock low after a start
		start_hold_d = two_wire && start_d && (start_hold_q || !scl_s_q[1]);
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			start_q <= 1'b0;
			start_hold_q <= 1'b0;
		end else begin
			start_q <= start_d;
			start_hold_q <= start_hold_d;
		end
	end

	// ---- output latch
	logic latch_q, latch_d, latch_open;

	always_comb begin
		// open in the half-cycle before the sampling edge; a shift or a write passes at once,
		// since the synchronised clock level arrives too late for the far side's next sample
		latch_open = !CLOCK_SOURCE_SELECT || DATA_WRITE || step.shift || (scl_s_q[1] != sample_rise);
		latch_d = latch_open ? data_d[shift_unit_pkg::MSB_POS] : latch_q;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			latch_q <= 1'b0;
		end else begin
			latch_q <= latch_d;
		end
	end

	// ---- clock pin toggle register
	logic scl_q, scl_d;

	always_comb begin
		// idles high, the level of a released clock line
		scl_d = scl_q ^ CLOCK_PIN_TOGGLE_STROBE;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			scl_q <= 1'b1;
		end else begin
			scl_q <= scl_d;
		end
	end

	// ---- status outputs
	logic [7:0] out_data_d;
	logic [3:0] out_count_d;
	logic out_ovf_d, out_start_d, out_ovf_irq_d, out_start_irq_d;

	always_comb begin
		out_data_d = data_d;
		out_count_d = count_d;
		out_ovf_d = ovf_d;
		out_start_d = start_d;
		out_ovf_irq_d = ovf_d & OVERFLOW_IRQ_ENABLE;
		out_start_irq_d = start_d & START_IRQ_ENABLE;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			SHIFT_DATA <= shift_unit_pkg::DATA_RESET;
			COUNT_VALUE <= shift_unit_pkg::COUNT_RESET;
			COUNTER_OVERFLOW_FLAG <= 1'b0;
			START_CONDITION_FLAG <= 1'b0;
			OVERFLOW_IRQ <= 1'b0;
			START_IRQ <= 1'b0;
		end else begin
			SHIFT_DATA <= out_data_d;
			COUNT_VALUE <= out_count_d;
			COUNTER_OVERFLOW_FLAG <= out_ovf_d;
			START_CONDITION_FLAG <= out_start_d;
			OVERFLOW_IRQ <= out_ovf_irq_d;
			START_IRQ <= out_start_irq_d;
		end
	end

	// ---- data pin drivers
	logic out_do_d, out_do_oe_n_d, out_sda_d, out_sda_oe_n_d;

	always_comb begin
		// three-wire: plain push-pull, no slave select input
		out_do_d = latch_d;
		out_do_oe_n_d = !(WIRE_MODE_SELECT == 2'(shift_unit_pkg::WIRE_THREE) && DATA_PIN_DRIVE);
		// two-wire: open drain, only ever pulls low
		out_sda_d = 1'b0;
		out_sda_oe_n_d = !(two_wire && DATA_PIN_DRIVE && !latch_d);
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			DATA_OUT <= 1'b0;
			DATA_OUT_OE_N <= 1'b1;
			SDA_OUT <= 1'b0;
			SDA_OE_N <= 1'b1;
		end else begin
			DATA_OUT <= out_do_d;
			DATA_OUT_OE_N <= out_do_oe_n_d;
			SDA_OUT <= out_sda_d;
			SDA_OE_N <= out_sda_oe_n_d;
		end
	end

	// ---- clock pin drivers
	logic ovf_hold;
	logic out_scl_d, out_scl_oe_n_d;

	always_comb begin
		ovf_hold = two_wire && ovf_d;
		if (two_wire) begin
			out_scl_d = 1'b0;
			out_scl_oe_n_d = !((CLOCK_PIN_DRIVE && !scl_d) || start_hold_d || ovf_hold);
		end else begin
			out_scl_d = scl_d;
			out_scl_oe_n_d = !CLOCK_PIN_DRIVE;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			SERIAL_CLOCK_PIN_OUT <= 1'b1;
			SERIAL_CLOCK_PIN_OE_N <= 1'b1;
		end else begin
			SERIAL_CLOCK_PIN_OUT <= out_scl_d;
			SERIAL_CLOCK_PIN_OE_N <= out_scl_oe_n_d;
		end
	end

endmodule

`default_nettype wire

// ===== inc/shift_unit_pkg.sv
package shift_unit_pkg;

	// wire modes of the unit
	typedef enum logic [1:0] {
		WIRE_OFF,
		WIRE_THREE,
		WIRE_TWO,
		WIRE_TWO_HOLD
	} wire_mode_t;

	// one clock event seen from the serial clock pin
	typedef struct packed {
		logic rise;
		logic fall;
	} edge_event_t;

	// steering of one shift/count step
	typedef struct packed {
		logic shift;
		logic count;
		logic data_bit;
	} step_t;

	localparam int DATA_WIDTH = 8;
	localparam int COUNT_WIDTH = 4;
	localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;
	localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 4'h0;
	localparam logic [COUNT_WIDTH-1:0] COUNT_MAX = 4'hf;
	localparam int MSB_POS = 7;

	// system clock and serial clock limits
	localparam int SYS_PERIOD_NS = 25;
	localparam int TWO_WIRE_DIVIDE = 16;
	localparam int THREE_WIRE_DIVIDE = 4;
	localparam int TWO_WIRE_MIN_PERIOD_NS = SYS_PERIOD_NS * TWO_WIRE_DIVIDE;
	localparam int THREE_WIRE_MIN_PERIOD_NS = SYS_PERIOD_NS * THREE_WIRE_DIVIDE;
	localparam int LINK_PERIOD_NS = 125;

endpackage

// ===== sim/universal_shift_unit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module universal_shift_unit_monitor (
	input wire logic CLK_SYS, // clock
	input wire logic RESET, // reset
	input wire logic [1:0] WIRE_MODE_SELECT, // wire mode
	input wire logic CLOCK_SOURCE_SELECT, // source
	input wire logic EXTERNAL_EDGE_SELECT, // edge or timer
	input wire logic SOFTWARE_CLOCK_STROBE, // sw step
	input wire logic TIMER0_MATCH, // timer step
	input wire logic DATA_WRITE, // data write
	input wire logic [7:0] DATA_WRITE_VALUE, // data value
	input wire logic COUNT_WRITE, // count write
	input wire logic [3:0] COUNT_WRITE_VALUE, // count value
	input wire logic OVERFLOW_IRQ_ENABLE, // irq enable
	input wire logic [7:0] SHIFT_DATA, // data
	input wire logic [3:0] COUNT_VALUE, // count
	input wire logic COUNTER_OVERFLOW_FLAG, // overflow
	input wire logic OVERFLOW_IRQ, // irq
	input wire logic SERIAL_CLOCK_PIN_OE_N // clock pin enable
);
	logic step;
	assign step = !CLOCK_SOURCE_SELECT && (EXTERNAL_EDGE_SELECT ? TIMER0_MATCH : SOFTWARE_CLOCK_STROBE) && !COUNT_WRITE;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RESET);
	chk_data_write: assert property (DATA_WRITE |=> SHIFT_DATA == $past(DATA_WRITE_VALUE))
		else $error("data write not taken");
	chk_count_write: assert property (COUNT_WRITE |=> COUNT_VALUE == $past(COUNT_WRITE_VALUE))
		else $error("count write not taken");
	chk_step_count: assert property (step |=> COUNT_VALUE == $past(COUNT_VALUE) + 4'h1)
		else $error("step did not count");
	chk_step_shift: assert property (step && !DATA_WRITE |=> SHIFT_DATA[7:1] == $past(SHIFT_DATA[6:0]))
		else $error("step did not shift");
	chk_wrap_flag: assert property (step && COUNT_VALUE == 4'hf |=> COUNTER_OVERFLOW_FLAG)
		else $error("wrap did not flag");
	chk_irq_gate: assert property ((COUNTER_OVERFLOW_FLAG && OVERFLOW_IRQ_ENABLE) [*2] |-> OVERFLOW_IRQ)
		else $error("overflow irq missing");
	chk_irq_mask: assert property ((!OVERFLOW_IRQ_ENABLE) [*2] |-> !OVERFLOW_IRQ)
		else $error("masked irq raised");
	chk_hold_low: assert property ((WIRE_MODE_SELECT[1] && COUNTER_OVERFLOW_FLAG) [*2] |-> !SERIAL_CLOCK_PIN_OE_N)
		else $error("overflow hold missing");
endmodule
bind universal_shift_unit universal_shift_unit_monitor mon_u (.CLK_SYS(CLK_SYS), .RESET(RESET),
	.WIRE_MODE_SELECT(WIRE_MODE_SELECT), .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT),
	.EXTERNAL_EDGE_SELECT(EXTERNAL_EDGE_SELECT), .SOFTWARE_CLOCK_STROBE(SOFTWARE_CLOCK_STROBE),
	.TIMER0_MATCH(TIMER0_MATCH), .DATA_WRITE(DATA_WRITE), .DATA_WRITE_VALUE(DATA_WRITE_VALUE),
	.COUNT_WRITE(COUNT_WRITE), .COUNT_WRITE_VALUE(COUNT_WRITE_VALUE), .OVERFLOW_IRQ_ENABLE(OVERFLOW_IRQ_ENABLE),
	.SHIFT_DATA(SHIFT_DATA), .COUNT_VALUE(COUNT_VALUE), .COUNTER_OVERFLOW_FLAG(COUNTER_OVERFLOW_FLAG),
	.OVERFLOW_IRQ(OVERFLOW_IRQ), .SERIAL_CLOCK_PIN_OE_N(SERIAL_CLOCK_PIN_OE_N));
`default_nettype wire

// ===== sim/serial_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
	input wire logic start, // begin a frame
	input wire logic mode, // 1: sample on falling edge
	input wire logic [7:0] tx, // byte sent
	input wire logic din, // device data out
	output logic sck, // link clock, idle low
	output logic dout, // data to device
	output logic [7:0] rx, // byte received
	output logic done // toggles per frame
);
	initial begin
		sck = 1'b0;
		dout = 1'b1;
		rx = 8'h00;
		done = 1'b0;
		forever begin
			@(posedge start);
			if (!mode) dout = tx[7];
			// keeps the link edges off the system clock edges
			#75.3;
			for (int i = 7; i >= 0; i--) begin
				sck = 1'b1;
				if (mode) dout = tx[i];
				else rx = {rx[6:0], din};
				#62.5;
				sck = 1'b0;
				if (mode) rx = {rx[6:0], din};
				else if (i > 0) dout = tx[i-1];
				#62.5;
			end
			dout = ~dout;
			done = ~done;
		end
	end
endmodule
`default_nettype wire

// ===== sim/universal_serial_shift_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module universal_serial_shift_unit_tb;
	logic clk_sys, rst = 1'b1, tb_scl = 1'b0, tb_sda = 1'b1, m_start = 1'b0, m_mode = 1'b0, d0;
	logic [8:0] cfg = 9'h000;
	logic [6:0] stb = 7'h00;
	logic [7:0] dwv = 8'h00, m_tx = 8'h00, dv, mt, sdata;
	logic [3:0] cwv = 4'h0, cnt;
	logic of, sf, oirq, sirq, dout, dout_oe_n, sda_out, sda_oe_n, scl_out, scl_oe_n, m_sck, m_sd, m_done;
	logic [7:0] m_rx;
	int fails = 0, comparisons = 0, k;
	wire scl_w = (m_sck | tb_scl) & (scl_oe_n | scl_out);
	wire sda_w = m_sd & tb_sda & (sda_oe_n | sda_out);
	universal_shift_unit dut_u (.CLK_SYS(clk_sys), .RESET(rst), .LINK_CLK(scl_w), .SERIAL_CLOCK_PIN_IN(scl_w),
		.SERIAL_DATA_INPUT(sda_w), .WIRE_MODE_SELECT(cfg[8:7]), .CLOCK_SOURCE_SELECT(cfg[6]),
		.EXTERNAL_EDGE_SELECT(cfg[5]), .COUNT_ON_TOGGLE(cfg[4]), .CLOCK_PIN_DRIVE(cfg[3]), .DATA_PIN_DRIVE(cfg[2]),
		.OVERFLOW_IRQ_ENABLE(cfg[1]), .START_IRQ_ENABLE(cfg[0]), .DATA_WRITE(stb[6]), .COUNT_WRITE(stb[5]),
		.SOFTWARE_CLOCK_STROBE(stb[4]), .TIMER0_MATCH(stb[3]), .OVERFLOW_FLAG_CLEAR(stb[2]),
		.START_FLAG_CLEAR(stb[1]), .CLOCK_PIN_TOGGLE_STROBE(stb[0]), .DATA_WRITE_VALUE(dwv), .COUNT_WRITE_VALUE(cwv),
		.SHIFT_DATA(sdata), .COUNT_VALUE(cnt), .COUNTER_OVERFLOW_FLAG(of), .START_CONDITION_FLAG(sf),
		.OVERFLOW_IRQ(oirq), .START_IRQ(sirq), .DATA_OUT(dout), .DATA_OUT_OE_N(dout_oe_n), .SDA_OUT(sda_out),
		.SDA_OE_N(sda_oe_n), .SERIAL_CLOCK_PIN_OUT(scl_out), .SERIAL_CLOCK_PIN_OE_N(scl_oe_n));
	serial_master_model master_u (.start(m_start), .mode(m_mode), .tx(m_tx), .din(dout), .sck(m_sck),
		.dout(m_sd), .rx(m_rx), .done(m_done));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task drive(input logic [8:0] c, input logic [6:0] s, input logic [7:0] d, input logic [3:0] n);
		@(posedge clk_sys);
		cfg <= c;
		stb <= s;
		dwv <= d;
		cwv <= n;
		@(posedge clk_sys);
		stb <= 7'h00;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	task end_of_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial begin
		#50000;
		fails++;
		end_of_test;
	end
	initial begin
		// link flops need link clock edges during and after reset
		repeat (6) begin
			repeat (3) @(posedge clk_sys);
			tb_scl <= ~tb_scl;
		end
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (6) begin
			repeat (3) @(posedge clk_sys);
			tb_scl <= ~tb_scl;
		end
		@(posedge clk_sys);
		#1;
		chk({sdata, cnt, of, sf, dout_oe_n, scl_out}, 16'h0003);
		$display("reset test done");
		drive(9'h002, 7'h60, 8'h81, 4'he);
		drive(9'h002, 7'h10, 8'h00, 4'h0);
		drive(9'h002, 7'h10, 8'h00, 4'h0);
		chk({sdata, cnt, of, oirq, 2'b00}, {8'h07, 4'h0, 4'hc});
		drive(9'h022, 7'h08, 8'h00, 4'h0);
		drive(9'h022, 7'h48, 8'h3c, 4'h0);
		chk({sdata, cnt, of, 3'b000}, {8'h3c, 4'h2, 4'h8});
		drive(9'h022, 7'h04, 8'h00, 4'h0);
		chk({of, oirq}, 16'h0000);
		$display("internal clock test done");
		for (int m = 0; m < 2; m++) begin
			dv = m ? 8'h69 : 8'h96;
			mt = m ? 8'h3c : 8'hc6;
			drive({3'b011, m[0], 5'b00100}, 7'h64, dv, 4'h0);
			m_mode = m[0];
			m_tx = mt;
			d0 = m_done;
			@(posedge clk_sys) m_start <= 1'b1;
			for (k = 0; k < 200 && m_done === d0; k++) @(posedge clk_sys);
			m_start <= 1'b0;
			repeat (6) @(posedge clk_sys);
			#1;
			chk({15'h0000, m_done !== d0}, 16'h0001);
			chk({sdata, m_rx}, {mt, dv});
			chk({cnt, of}, 16'h0001);
			$display("external mode %0d test done", m);
		end
		drive(9'h0d8, 7'h24, 8'h00, 4'h0);
		drive(9'h0d8, 7'h01, 8'h00, 4'h0);
		chk({scl_out, cnt}, 16'h0001);
		$display("toggle test done");
		drive(9'h141, 7'h06, 8'h00, 4'h0);
		@(posedge clk_sys) tb_scl <= 1'b1;
		repeat (4) @(posedge clk_sys);
		tb_sda <= 1'b0;
		repeat (6) @(posedge clk_sys);
		#1;
		chk({sf, sirq}, 16'h0003);
		@(posedge clk_sys) tb_scl <= 1'b0;
		repeat (6) @(posedge clk_sys);
		tb_scl <= 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		chk({scl_oe_n, scl_w}, 16'h0000);
		drive(9'h141, 7'h02, 8'h00, 4'h0);
		chk({sf, scl_oe_n, scl_w}, 16'h0003);
		drive(9'h101, 7'h20, 8'h00, 4'hf);
		drive(9'h101, 7'h10, 8'h00, 4'h0);
		chk({of, scl_oe_n}, 16'h0002);
		drive(9'h101, 7'h04, 8'h00, 4'h0);
		chk({of, scl_oe_n}, 16'h0001);
		$display("two-wire test done");
		end_of_test;
	end
endmodule
`default_nettype wire
